/* File: verilog/rtcco_top.sv */
`timescale 1ns/10ps
module rtcco_top
    import rtcco_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_xtal_osc,
    input  wire logic       i_crystal_input_pin,
    input  wire logic       i_on_backup,
    input  wire logic       i_trim_direction,
    input  wire logic       i_alarm_zero_match,
    input  wire logic       i_alarm_one_match,
    output logic            o_multi_function_pin,
    output logic            o_alarm_zero_enable,
    output logic            o_alarm_one_enable,
    output logic            o_external_timebase_enable,
    output logic            o_second_tick
);

////////////////////////////////////////////////////////////////////////////////

    logic [6:0]  control;
    logic [7:0]  trim_amount;
    logic        square_wave_enable;
    logic        coarse_trim_enable;
    logic        external_timebase_enable;
    logic        alarm_zero_enable;
    logic        alarm_one_enable;
    logic [1:0]  square_wave_freq_select;

    logic        osc_sel;
    logic        osc_prev;
    logic        raw_tick;
    rtcco_trim_t trim_state;
    logic [8:0]  trim_left;
    logic        trim_tick;
    logic [14:0] tick_cnt;
    logic [5:0]  sec_cnt;
    logic        tick_wrap;
    logic        trim_adjust;
    logic        square_wave_output;
    logic        alarm_out;
    logic        next_pin;

    assign square_wave_enable       = control[RTCCO_SQW_EN_BIT];
    assign alarm_one_enable         = control[RTCCO_ALM1_EN_BIT];
    assign alarm_zero_enable        = control[RTCCO_ALM0_EN_BIT];
    assign external_timebase_enable = control[RTCCO_EXT_TB_BIT];
    assign coarse_trim_enable       = control[RTCCO_COARSE_BIT];
    assign square_wave_freq_select  = control[RTCCO_FS_MSB:RTCCO_FS_LSB];

    // picks the postscaler tap for a select code
    function automatic logic freq_tap(input logic [1:0] sel, input logic [14:0] cnt, input logic osc);
        logic tap;
        tap = cnt[RTCCO_TAP_1HZ];
        if (sel == RTCCO_FS_4K) begin
            tap = cnt[RTCCO_TAP_4K];
        end else if (sel == RTCCO_FS_8K) begin
            tap = cnt[RTCCO_TAP_8K];
        end else if (sel == RTCCO_FS_RAW) begin
            tap = osc;
        end
        return tap;
    endfunction

////////////////////////////////////////////////////////////////////////////////
// register access

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            control     <= RTCCO_CONTROL_RST;
            trim_amount <= RTCCO_TRIM_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == RTCCO_CONTROL_ADDR) begin
                control <= i_reg_wdata[6:0];
            end else if (i_reg_addr == RTCCO_TRIM_ADDR) begin
                trim_amount <= i_reg_wdata;
            end
        end
    end

    // top control bit is unimplemented and reads as one
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= RTCCO_UNMAPPED_DATA;
        end else if (i_reg_rd) begin
            if (i_reg_addr == RTCCO_CONTROL_ADDR) begin
                o_reg_rdata <= {RTCCO_CTRL_TOP_READ, control};
            end else if (i_reg_addr == RTCCO_TRIM_ADDR) begin
                o_reg_rdata <= trim_amount;
            end else begin
                o_reg_rdata <= RTCCO_UNMAPPED_DATA;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// timebase

    assign osc_sel  = external_timebase_enable ? i_crystal_input_pin : i_xtal_osc;
    assign raw_tick = osc_sel && !osc_prev;

    // switching source can cost or add one tick; acceptable at configuration time
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            osc_prev <= 1'b0;
        end else begin
            osc_prev <= osc_sel;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// digital trimming

    // two ticks per step over a minute of 32768*60 ticks, or over each second of 32768 ticks when coarse trim is on
    assign tick_wrap   = trim_tick && (tick_cnt == RTCCO_TICK_WRAP);
    assign trim_adjust = tick_wrap && (coarse_trim_enable || sec_cnt == RTCCO_SEC_LAST);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            trim_state <= RTCCO_TRIM_IDLE;
            trim_left  <= 9'h000;
        end else begin
            case (trim_state)
                RTCCO_TRIM_IDLE: begin
                    if (trim_adjust && trim_amount != 8'h00) begin
                        trim_left  <= {trim_amount, 1'b0};
                        trim_state <= i_trim_direction ? RTCCO_TRIM_INSERT : RTCCO_TRIM_REMOVE;
                    end
                end
                RTCCO_TRIM_REMOVE: begin
                    if (raw_tick) begin
                        trim_left <= trim_left - 9'h001;
                        if (trim_left == 9'h001) begin
                            trim_state <= RTCCO_TRIM_IDLE;
                        end
                    end
                end
                RTCCO_TRIM_INSERT: begin
                    if (!raw_tick) begin
                        trim_left <= trim_left - 9'h001;
                        if (trim_left == 9'h001) begin
                            trim_state <= RTCCO_TRIM_IDLE;
                        end
                    end
                end
                default: begin
                    trim_state <= RTCCO_TRIM_IDLE;
                end
            endcase
        end
    end

    // inserted ticks use system clock cycles between oscillator edges,
    // so up to 510 of them take 510 such cycles, spread over several oscillator periods
    // swallow or add ticks
    assign trim_tick = (raw_tick && trim_state != RTCCO_TRIM_REMOVE)
                     || (trim_state == RTCCO_TRIM_INSERT && !raw_tick);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tick_cnt <= 15'h0000;
        end else if (trim_tick) begin
            tick_cnt <= tick_cnt + 15'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sec_cnt <= 6'h00;
        end else if (tick_wrap) begin
            sec_cnt <= (sec_cnt == RTCCO_SEC_LAST) ? 6'h00 : sec_cnt + 6'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_second_tick <= 1'b0;
        end else begin
            o_second_tick <= tick_wrap;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// multi-function pin

    assign square_wave_output = coarse_trim_enable ? tick_cnt[RTCCO_TAP_1HZ]
                              : freq_tap(square_wave_freq_select, tick_cnt, osc_sel);

    assign alarm_out = (i_alarm_zero_match && alarm_zero_enable) || (i_alarm_one_match && alarm_one_enable);

    assign next_pin = square_wave_enable ? (!i_on_backup && square_wave_output) : alarm_out;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_multi_function_pin <= 1'b0;
        end else begin
            o_multi_function_pin <= next_pin;
        end
    end

    assign o_alarm_zero_enable        = alarm_zero_enable;
    assign o_alarm_one_enable         = alarm_one_enable;
    assign o_external_timebase_enable = external_timebase_enable;

////////////////////////////////////////////////////////////////////////////////
// assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence sqw_live_s;
        square_wave_enable && !i_on_backup;
    endsequence

    sequence adjust_insert_s;
        trim_state == RTCCO_TRIM_IDLE && trim_adjust && trim_amount != 8'h00 && i_trim_direction;
    endsequence

    sequence adjust_remove_s;
        trim_state == RTCCO_TRIM_IDLE && trim_adjust && trim_amount != 8'h00 && !i_trim_direction;
    endsequence

    sqw_pin_follow_a: assert property (sqw_live_s |=> o_multi_function_pin == $past(square_wave_output))
        else $error("pin does not follow square wave");

    backup_blank_a: assert property (square_wave_enable && i_on_backup |=> !o_multi_function_pin)
        else $error("square wave not blanked on backup");

    alarm_pin_a: assert property (!square_wave_enable |=> o_multi_function_pin == $past(alarm_out))
        else $error("alarm mode pin mismatch");

    alarm_backup_a: assert property (!square_wave_enable && i_on_backup && i_alarm_zero_match
        && alarm_zero_enable |=> o_multi_function_pin)
        else $error("alarm lost on backup");

    raw_bypass_a: assert property (sqw_live_s ##0 !coarse_trim_enable
        && square_wave_freq_select == RTCCO_FS_RAW |=> o_multi_function_pin == $past(osc_sel))
        else $error("1:1 rate not bypassed");

    tap_1hz_a: assert property (sqw_live_s ##0 !coarse_trim_enable
        && square_wave_freq_select == RTCCO_FS_1HZ |=> o_multi_function_pin == $past(tick_cnt[RTCCO_TAP_1HZ]))
        else $error("1 Hz tap wrong");

    tap_4k_a: assert property (sqw_live_s ##0 !coarse_trim_enable
        && square_wave_freq_select == RTCCO_FS_4K |=> o_multi_function_pin == $past(tick_cnt[RTCCO_TAP_4K]))
        else $error("1:8 tap wrong");

    tap_8k_a: assert property (sqw_live_s ##0 !coarse_trim_enable
        && square_wave_freq_select == RTCCO_FS_8K |=> o_multi_function_pin == $past(tick_cnt[RTCCO_TAP_8K]))
        else $error("1:4 tap wrong");

    coarse_tap_a: assert property (sqw_live_s ##0 coarse_trim_enable
        |=> o_multi_function_pin == $past(tick_cnt[RTCCO_TAP_1HZ]))
        else $error("coarse mode not 1 Hz");

    insert_load_a: assert property (adjust_insert_s |=> trim_state == RTCCO_TRIM_INSERT
        && trim_left == {$past(trim_amount), 1'b0})
        else $error("insert count wrong");

    remove_swallow_a: assert property (adjust_remove_s |=> trim_state == RTCCO_TRIM_REMOVE
        && trim_left == {$past(trim_amount), 1'b0} && (!raw_tick || !trim_tick))
        else $error("remove does not swallow tick");

    insert_add_a: assert property (trim_state == RTCCO_TRIM_INSERT && !raw_tick
        |-> trim_tick)
        else $error("insert does not add tick");

    remove_count_a: assert property (trim_state == RTCCO_TRIM_REMOVE && raw_tick && trim_left != 9'h001
        |=> trim_state == RTCCO_TRIM_REMOVE && trim_left == $past(trim_left) - 9'h001)
        else $error("remove count does not step");

    insert_count_a: assert property (trim_state == RTCCO_TRIM_INSERT && !raw_tick && trim_left != 9'h001
        |=> trim_state == RTCCO_TRIM_INSERT && trim_left == $past(trim_left) - 9'h001)
        else $error("insert count does not step");

    backup_trim_a: assert property (i_on_backup && trim_state == RTCCO_TRIM_IDLE && trim_adjust
        && trim_amount != 8'h00 |=> trim_state != RTCCO_TRIM_IDLE)
        else $error("trim stopped on backup");

    zero_trim_a: assert property (trim_state == RTCCO_TRIM_IDLE && trim_amount == 8'h00
        |=> trim_state == RTCCO_TRIM_IDLE)
        else $error("zero trim started an adjust");

    fine_minute_a: assert property (tick_wrap && !coarse_trim_enable && sec_cnt != RTCCO_SEC_LAST
        |-> !trim_adjust)
        else $error("fine trim applied mid minute");

    coarse_second_a: assert property (tick_wrap && coarse_trim_enable |-> trim_adjust)
        else $error("coarse trim missed a second");

    second_tick_a: assert property (tick_wrap |=> o_second_tick)
        else $error("second tick missing");

    ext_source_a: assert property (external_timebase_enable && i_crystal_input_pin && !osc_prev
        |-> raw_tick)
        else $error("external edge not taken");

endmodule

/* File: pkg/rtcco_pkg.sv */
package rtcco_pkg;

    // register map
    localparam logic [7:0]  RTCCO_CONTROL_ADDR   = 8'h08;
    localparam logic [7:0]  RTCCO_TRIM_ADDR      = 8'h09;
    localparam logic [6:0]  RTCCO_CONTROL_RST    = 7'h00;
    localparam logic [7:0]  RTCCO_TRIM_RST       = 8'h00;
    localparam logic [7:0]  RTCCO_UNMAPPED_DATA  = 8'h00;

    // control field positions
    localparam int          RTCCO_SQW_EN_BIT     = 6;
    localparam int          RTCCO_ALM1_EN_BIT    = 5;
    localparam int          RTCCO_ALM0_EN_BIT    = 4;
    localparam int          RTCCO_EXT_TB_BIT     = 3;
    localparam int          RTCCO_COARSE_BIT     = 2;
    localparam int          RTCCO_FS_MSB         = 1;
    localparam int          RTCCO_FS_LSB         = 0;
    localparam logic        RTCCO_CTRL_TOP_READ  = 1'b1;

    // frequency select codes
    localparam logic [1:0]  RTCCO_FS_1HZ         = 2'h0;
    localparam logic [1:0]  RTCCO_FS_4K          = 2'h1;
    localparam logic [1:0]  RTCCO_FS_8K          = 2'h2;
    localparam logic [1:0]  RTCCO_FS_RAW         = 2'h3;

    // postscaler taps on the trimmed tick counter (1:32768, 1:8, 1:4)
    localparam int          RTCCO_TAP_1HZ        = 14;
    localparam int          RTCCO_TAP_4K         = 2;
    localparam int          RTCCO_TAP_8K         = 1;

    // timebase counts
    localparam logic [14:0] RTCCO_TICK_WRAP      = 15'h7FFF;
    localparam logic [5:0]  RTCCO_SEC_LAST       = 6'h3B;

    typedef enum {
        RTCCO_TRIM_IDLE,
        RTCCO_TRIM_REMOVE,
        RTCCO_TRIM_INSERT
    } rtcco_trim_t;

endpackage

/* File: testbench/rtcco_host_model.sv */
`timescale 1ns/10ps
module rtcco_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_osc_run,
    input  wire logic        i_ext_run,
    input  wire logic        i_multi_function_pin,
    output logic             o_xtal_osc,
    output logic             o_crystal_input_pin,
    output logic [15:0]      o_rise_count
);
    logic [1:0] div;
    logic       pin_q;

    initial begin
        div = 2'h0;
        pin_q = 1'b0;
        o_rise_count = 16'h0000;
    end

    // sources stand low while stopped, so a dead source never shows stale edges
    assign o_xtal_osc          = i_osc_run & div[1];
    assign o_crystal_input_pin = i_ext_run & div[1];

    ////////////////////////////////////////////////////////////////////////
    // host side counts rising edges of the pin
    always @(posedge i_clk) begin
        div <= div + 2'h1;
        pin_q <= i_multi_function_pin;
        if (i_multi_function_pin === 1'b1 && pin_q === 1'b0) begin
            o_rise_count <= o_rise_count + 16'h0001;
        end
    end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/10ps
module tb;
    import rtcco_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, bkp = 1'b0, tdir = 1'b0;
    logic        alm0 = 1'b0, alm1 = 1'b0, osc_run = 1'b1, ext_run = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic        xtal, ext, pin, a0_en, a1_en, ext_en;
    logic [15:0] rises;
    int          err_count = 0, num_checks = 0;

    always #2 clk = ~clk;

    rtcco_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_xtal_osc(xtal), .i_crystal_input_pin(ext),
        .i_on_backup(bkp), .i_trim_direction(tdir), .i_alarm_zero_match(alm0), .i_alarm_one_match(alm1),
        .o_multi_function_pin(pin), .o_alarm_zero_enable(a0_en), .o_alarm_one_enable(a1_en),
        .o_external_timebase_enable(ext_en), .o_second_tick());

    rtcco_host_model host_u (.i_clk(clk), .i_osc_run(osc_run), .i_ext_run(ext_run),
        .i_multi_function_pin(pin), .o_xtal_osc(xtal), .o_crystal_input_pin(ext), .o_rise_count(rises));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr    = 1'b1;
        addr  = a;
        wdata = d;
        step(1);
        wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        rd   = 1'b1;
        addr = a;
        step(1);
        rd = 1'b0;
        check(rdata, exp, "read data");
    endtask

    task automatic count_rises(input int cycles, input int lo, input int hi);
        int c0;
        int n;
        step(8);
        c0 = rises;
        step(cycles);
        n = rises - c0;
        check({7'h00, n >= lo && n <= hi}, 8'h01, "pin edge count");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        reg_rd(RTCCO_CONTROL_ADDR, 8'h80);
        reg_rd(RTCCO_TRIM_ADDR, 8'h00);
        reg_rd(8'h0A, RTCCO_UNMAPPED_DATA);
        reg_wr(RTCCO_CONTROL_ADDR, 8'h7F);
        reg_wr(8'h0A, 8'h12);
        reg_rd(RTCCO_CONTROL_ADDR, 8'hFF);
        reg_wr(RTCCO_TRIM_ADDR, 8'hA5);
        reg_rd(RTCCO_TRIM_ADDR, 8'hA5);
        reg_wr(RTCCO_CONTROL_ADDR, 8'h00);
        reg_wr(RTCCO_TRIM_ADDR, 8'h00);
        $display("test_regs done");
    endtask

    task automatic test_alarm();
        reg_wr(RTCCO_CONTROL_ADDR, 8'h30);
        check({6'h00, a1_en, a0_en}, 8'h03, "alarm enables");
        alm0 = 1'b1;
        step(2);
        check({7'h00, pin}, 8'h01, "alarm zero on pin");
        bkp = 1'b1;
        step(2);
        check({7'h00, pin}, 8'h01, "alarm kept on backup");
        reg_wr(RTCCO_CONTROL_ADDR, 8'h10);
        alm0 = 1'b0;
        alm1 = 1'b1;
        step(2);
        check({7'h00, pin}, 8'h00, "disabled alarm masked");
        reg_wr(RTCCO_CONTROL_ADDR, 8'h20);
        step(2);
        check({7'h00, pin}, 8'h01, "alarm one on pin");
        alm1 = 1'b0;
        bkp = 1'b0;
        $display("test_alarm done");
    endtask

    task automatic test_rates();
        // 128 cycles hold 32 oscillator periods
        int exp_r[4] = '{0, 4, 8, 32};
        for (int s = 3; s >= 0; s--) begin
            reg_wr(RTCCO_CONTROL_ADDR, 8'h40 | 8'(s));
            count_rises(128, exp_r[s] - (s > 0), exp_r[s] + (s > 0));
        end
        reg_wr(RTCCO_CONTROL_ADDR, 8'h43);
        bkp = 1'b1;
        count_rises(64, 0, 0);
        bkp = 1'b0;
        count_rises(128, 31, 33);
        reg_wr(RTCCO_CONTROL_ADDR, 8'h47);
        count_rises(128, 0, 0);
        reg_wr(RTCCO_CONTROL_ADDR, 8'h03);
        count_rises(128, 0, 0);
        $display("test_rates done");
    endtask

    task automatic test_ext();
        reg_wr(RTCCO_CONTROL_ADDR, 8'h4B);
        osc_run = 1'b0;
        ext_run = 1'b1;
        check({7'h00, ext_en}, 8'h01, "external enable");
        count_rises(128, 31, 33);
        ext_run = 1'b0;
        count_rises(64, 0, 0);
        osc_run = 1'b1;
        $display("test_ext done");
    endtask

    task automatic test_calib();
        int trim;
        // zero trim, 1:4 rate, square wave on, measure
        reg_wr(RTCCO_TRIM_ADDR, 8'h00);
        reg_wr(RTCCO_CONTROL_ADDR, 8'h42);
        count_rises(128, 7, 9);
        // 8191.9 Hz measured against 8192 Hz, in tenths of a hertz
        trim = (81920 - 81919) * 32768 * 60 / 81920 / 2;
        // positive error means slow oscillator, so insert
        tdir = (trim > 0);
        reg_wr(RTCCO_TRIM_ADDR, 8'(trim));
        reg_rd(RTCCO_TRIM_ADDR, 8'h0C);
        // one second gained over 100000 seconds is 10 ppm
        trim = 1 * 1000000 / 100000;
        trim = trim * 32768 * 60 / (1000000 * 2);
        // gained time means fast oscillator, so remove
        tdir = 1'b0;
        reg_wr(RTCCO_TRIM_ADDR, 8'(trim));
        reg_rd(RTCCO_TRIM_ADDR, 8'h09);
        reg_wr(RTCCO_TRIM_ADDR, 8'h00);
        $display("test_calib done");
    endtask

    task automatic test_reset();
        reg_wr(RTCCO_CONTROL_ADDR, 8'h73);
        reg_wr(RTCCO_TRIM_ADDR, 8'h55);
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        check({5'h00, ext_en, a1_en, a0_en}, 8'h00, "enables after reset");
        reg_rd(RTCCO_CONTROL_ADDR, 8'h80);
        reg_rd(RTCCO_TRIM_ADDR, 8'h00);
        check({7'h00, pin}, 8'h00, "pin after reset");
        $display("test_reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        complete_run();
    end

    initial begin
        step(12);
        rst_n = 1'b1;
        test_regs();
        test_alarm();
        test_rates();
        test_ext();
        test_calib();
        test_reset();
        complete_run();
    end
endmodule
